// *** verilog/ufce_consts.vh ***
`ifndef UFCE_CONSTS_VH
`define UFCE_CONSTS_VH
// register indices on the 4-bit address port
`define UFCE_A_HOLD    4'h0
`define UFCE_A_IER     4'h1
`define UFCE_A_FCR     4'h2
`define UFCE_A_LCR     4'h3
`define UFCE_A_MCR     4'h4
`define UFCE_A_LSR     4'h5
`define UFCE_A_MSR     4'h6
`define UFCE_A_SCR     4'h7
`define UFCE_A_FFC     4'h8
`define UFCE_A_RESUME_CHAR_ONE    4'h9
`define UFCE_A_RESUME_CHAR_TWO    4'ha
`define UFCE_A_PAUSE_CHAR_ONE   4'hb
`define UFCE_A_PAUSE_CHAR_TWO   4'hc
`define UFCE_A_ISR     4'hd
// reset values
`define UFCE_RST_ZERO  8'h00
`define UFCE_RST_ISR   8'h01
`define UFCE_RST_LSR   8'h60
`define UFCE_RST_SCR   8'hff
`define UFCE_RST_QUAD_FIFO_STATUS 8'hff
// field positions in flow_feature_control
`define UFCE_F_ENH     4
`define UFCE_F_SPEC    5
`define UFCE_F_ARTS    6
`define UFCE_F_ACTS    7
// protected bit masks
`define UFCE_M_IER     8'hf0
`define UFCE_M_ISR     8'h30
`define UFCE_M_FCR     8'h30
`define UFCE_M_MCR     8'he0
// interrupt status bit positions
`define UFCE_I_SPEC    4
`define UFCE_I_PAUSE   5
// rts bit in modem control
`define UFCE_MCR_RTS   1
`endif

// *** verilog/ufce_rx_match.v ***
`include "ufce_consts.vh"
module ufce_rx_match (
  // clock and reset
  input  wire       clock,
  input  wire       rst,
  input  wire       clk_en,
  // configuration
  input  wire [7:0] ffc,
  input  wire [7:0] resume_char_one,
  input  wire [7:0] resume_char_two,
  input  wire [7:0] pause_char_one,
  input  wire [7:0] pause_char_two,
  // received character
  input  wire       rx_valid,
  input  wire [7:0] rx_char,
  // results
  output reg        pause_hit,
  output reg        resume_hit,
  output reg        spec_hit,
  output reg        drop_char,
  output reg        wr_valid,
  output reg  [7:0] wr_char
);
  reg       pend_off;
  reg       pend_on;
  reg       any_off, any_on, seq_off, seq_on, is_spec, drop, dual;
  always @* begin
    dual = (ffc[1:0] == 2'b11) && (ffc[3] == ffc[2]);
    any_off = 1'b0;
    any_on = 1'b0;
    seq_off = 1'b0;
    seq_on = 1'b0;
    case (ffc[1:0])
      2'b10: begin
        any_off = rx_char == pause_char_one;
        any_on = rx_char == resume_char_one;
      end
      2'b01: begin
        any_off = rx_char == pause_char_two;
        any_on = rx_char == resume_char_two;
      end
      2'b11: begin
        if (!dual) begin
          any_off = (rx_char == pause_char_one) || (rx_char == pause_char_two);
          any_on = (rx_char == resume_char_one) || (rx_char == resume_char_two);
        end else begin
          seq_off = pend_off && (rx_char == pause_char_two);
          seq_on = pend_on && (rx_char == resume_char_two);
        end
      end
      default: begin
        any_off = 1'b0;
      end
    endcase
    is_spec = ffc[`UFCE_F_SPEC] && (rx_char == pause_char_two);
    // flow chars kept out of fifo (in two-char mode only the second of the pair); a single-char pause match on the special char is kept unless mode 01
    drop = any_off || any_on || seq_off || seq_on;
    if (is_spec && ffc[1:0] != 2'b01)
      drop = seq_off || seq_on || any_on;
  end
  always @(posedge clock) begin
    if (rst) begin
      pend_off <= 1'b0;
      pend_on <= 1'b0;
      pause_hit <= 1'b0;
      resume_hit <= 1'b0;
      spec_hit <= 1'b0;
      drop_char <= 1'b0;
      wr_valid <= 1'b0;
      wr_char <= `UFCE_RST_ZERO;
    end else if (clk_en) begin
      pause_hit <= 1'b0;
      resume_hit <= 1'b0;
      spec_hit <= 1'b0;
      drop_char <= 1'b0;
      wr_valid <= 1'b0;
      if (rx_valid) begin
        pend_off <= dual && (rx_char == pause_char_one);
        pend_on <= dual && (rx_char == resume_char_one);
        pause_hit <= any_off || seq_off;
        resume_hit <= any_on || seq_on;
        spec_hit <= is_spec;
        drop_char <= drop;
        wr_valid <= !drop;
        wr_char <= rx_char;
      end
    end
  end
endmodule

// *** verilog/ufce_tx_flow.v ***
`include "ufce_consts.vh"
module ufce_tx_flow (
  // clock and reset
  input  wire       clock,
  input  wire       rst,
  input  wire       clk_en,
  // configuration
  input  wire [7:0] ffc,
  input  wire [7:0] resume_char_one,
  input  wire [7:0] resume_char_two,
  input  wire [7:0] pause_char_one,
  input  wire [7:0] pause_char_two,
  // requests
  input  wire       send_pause,
  input  wire       send_resume,
  input  wire       cts_sync_n,
  input  wire       remote_paused,
  input  wire       data_valid,
  input  wire [7:0] data_char,
  output wire       data_ready,
  // to serialiser
  input  wire       ser_ready,
  output reg        ser_valid,
  output reg  [7:0] ser_char
);
  localparam S_IDLE = 2'd0;
  localparam S_SECOND = 2'd1;
  reg [1:0] state;
  reg       second_off;
  wire      hold_data;
  // stop data while paused or, with auto cts enabled, while cts high
  assign hold_data = (ffc[`UFCE_F_ACTS] && cts_sync_n) || remote_paused;
  assign data_ready = ser_ready && !ser_valid && state == S_IDLE &&
                      !send_pause && !send_resume && !hold_data;
  always @(posedge clock) begin
    if (rst) begin
      state <= S_IDLE;
      second_off <= 1'b0;
      ser_valid <= 1'b0;
      ser_char <= `UFCE_RST_ZERO;
    end else if (clk_en) begin
      if (ser_valid && ser_ready)
        ser_valid <= 1'b0;
      else if (!ser_valid) begin
        case (state)
          S_IDLE: begin
            if ((send_pause || send_resume) && ffc[3:2] != 2'b00) begin
              ser_valid <= 1'b1;
              second_off <= send_pause;
              if (ffc[3:2] == 2'b01)
                ser_char <= send_pause ? pause_char_two : resume_char_two;
              else
                ser_char <= send_pause ? pause_char_one : resume_char_one;
              if (ffc[3:2] == 2'b11)
                state <= S_SECOND;
            end else if (data_valid && !hold_data && ser_ready) begin
              ser_valid <= 1'b1;
              ser_char <= data_char;
            end
          end
          S_SECOND: begin
            ser_valid <= 1'b1;
            ser_char <= second_off ? pause_char_two : resume_char_two;
            state <= S_IDLE;
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end
endmodule

// *** verilog/ufce_top.v ***
`include "ufce_consts.vh"
module ufce_top #(
  parameter UPPER_LEVEL = 8'd60,
  parameter LOWER_LEVEL = 8'd40,
  parameter TRIG_LEVEL  = 8'd56
) (
  // clock, reset, enable
  input  wire       clock,
  input  wire       rst,
  input  wire       clk_en,
  // host bus
  input  wire [3:0] addr,
  input  wire       wr_en,
  input  wire       rd_en,
  input  wire [7:0] wr_data,
  output reg  [7:0] rd_data,
  output wire       rd_data_oe,
  input  wire       status_read_select_n,
  // four channel ready pins
  input  wire [3:0] tx_space_ready_n,
  input  wire [3:0] rx_data_ready_n,
  // modem pins
  input  wire       cts_n,
  input  wire [3:0] modem_in_n,
  output reg        rts_n,
  output reg        dtr_n,
  output reg        infrared_tx_out,
  output reg        irq_n,
  // receive path
  input  wire       rx_valid,
  input  wire [7:0] rx_char,
  input  wire [7:0] rx_fill,
  output wire       rx_wr_valid,
  output wire [7:0] rx_wr_char,
  output wire       rx_trigger_irq,
  // transmit path
  input  wire       tx_valid,
  input  wire [7:0] tx_char,
  output wire       tx_ready,
  input  wire       ser_ready,
  output wire       ser_valid,
  output wire [7:0] ser_char,
  output reg        tx_line_idle
);
  reg  [7:0] interrupt_enable_reg, fifo_control_reg, line_control_reg, modem_control_reg, line_status_reg, scr, ffc, interrupt_status_reg;
  reg  [7:0] resume_char_one, resume_char_two, pause_char_one, pause_char_two;
  reg  [7:0] modem_status_reg;
  reg  [1:0] cts_s;
  reg  [3:0] mi_s1, mi_s2;
  reg  [3:0] txr_s1, txr_s2, rxr_s1, rxr_s2;
  reg        rts_armed, auto_hi, remote_paused, we_paused, fs_s1, fs_s2;
  wire       pause_hit, resume_hit, spec_hit;
  wire       enh;
  reg        send_pause, send_resume;
  wire [7:0] quad_fifo_status;
  assign enh = ffc[`UFCE_F_ENH];

  function [7:0] ufce_merge;
    input [7:0] old_v;
    input [7:0] new_v;
    input [7:0] mask;
    input       allow;
    begin
      ufce_merge = allow ? new_v : ((old_v & mask) | (new_v & ~mask));
    end
  endfunction

  always @(posedge clock) begin
    if (rst) begin
      cts_s <= 2'b11;
      txr_s1 <= 4'h0;
      txr_s2 <= 4'h0;
      rxr_s1 <= 4'hf;
      rxr_s2 <= 4'hf;
      fs_s1 <= 1'b1;
      fs_s2 <= 1'b1;
    end else if (clk_en) begin
      cts_s <= {cts_s[0], cts_n};
      txr_s1 <= tx_space_ready_n;
      txr_s2 <= txr_s1;
      rxr_s1 <= rx_data_ready_n;
      rxr_s2 <= rxr_s1;
      fs_s1 <= status_read_select_n;
      fs_s2 <= fs_s1;
    end
  end

  always @(posedge clock) begin
    if (clk_en) begin
      mi_s1 <= modem_in_n;
      mi_s2 <= mi_s1;
    end
  end

  assign quad_fifo_status = {rxr_s2, ~txr_s2};

  always @(posedge clock) begin
    if (rst) begin
      interrupt_enable_reg <= `UFCE_RST_ZERO;
      fifo_control_reg <= `UFCE_RST_ZERO;
      line_control_reg <= `UFCE_RST_ZERO;
      modem_control_reg <= `UFCE_RST_ZERO;
      line_status_reg <= `UFCE_RST_LSR;
      scr <= `UFCE_RST_SCR;
      ffc <= `UFCE_RST_ZERO;
      interrupt_status_reg <= `UFCE_RST_ISR;
      resume_char_one <= `UFCE_RST_ZERO;
      resume_char_two <= `UFCE_RST_ZERO;
      pause_char_one <= `UFCE_RST_ZERO;
      pause_char_two <= `UFCE_RST_ZERO;
      modem_status_reg <= {~mi_s2, 4'h0};
    end else if (clk_en) begin
      modem_status_reg[7:4] <= ~mi_s2;
      if (wr_en) begin
        case (addr)
          `UFCE_A_IER: interrupt_enable_reg <= ufce_merge(interrupt_enable_reg, wr_data, `UFCE_M_IER, enh);
          `UFCE_A_FCR: fifo_control_reg <= ufce_merge(fifo_control_reg, wr_data, `UFCE_M_FCR, enh);
          `UFCE_A_LCR: line_control_reg <= wr_data;
          `UFCE_A_MCR: modem_control_reg <= ufce_merge(modem_control_reg, wr_data, `UFCE_M_MCR, enh);
          `UFCE_A_SCR: scr <= wr_data;
          `UFCE_A_FFC: ffc <= wr_data;
          `UFCE_A_RESUME_CHAR_ONE: resume_char_one <= wr_data;
          `UFCE_A_RESUME_CHAR_TWO: resume_char_two <= wr_data;
          `UFCE_A_PAUSE_CHAR_ONE: pause_char_one <= wr_data;
          `UFCE_A_PAUSE_CHAR_TWO: pause_char_two <= wr_data;
          default: line_status_reg <= line_status_reg;
        endcase
      end
      // status enhanced bits writable only when enabled; set wins
      if (wr_en && addr == `UFCE_A_ISR && enh)
        interrupt_status_reg[5:4] <= wr_data[5:4];
      if (spec_hit)
        interrupt_status_reg[`UFCE_I_SPEC] <= 1'b1;
      if (pause_hit)
        interrupt_status_reg[`UFCE_I_PAUSE] <= 1'b1;
    end
  end

  assign rd_data_oe = !fs_s2 || rd_en;
  always @(posedge clock) begin
    if (rst)
      rd_data <= `UFCE_RST_ZERO;
    else if (clk_en) begin
      if (!fs_s2)
        rd_data <= quad_fifo_status;
      else
        case (addr)
          `UFCE_A_IER: rd_data <= interrupt_enable_reg;
          `UFCE_A_FCR: rd_data <= fifo_control_reg;
          `UFCE_A_LCR: rd_data <= line_control_reg;
          `UFCE_A_MCR: rd_data <= modem_control_reg;
          `UFCE_A_LSR: rd_data <= line_status_reg;
          `UFCE_A_MSR: rd_data <= modem_status_reg;
          `UFCE_A_SCR: rd_data <= scr;
          `UFCE_A_FFC: rd_data <= ffc;
          `UFCE_A_RESUME_CHAR_ONE: rd_data <= resume_char_one;
          `UFCE_A_RESUME_CHAR_TWO: rd_data <= resume_char_two;
          `UFCE_A_PAUSE_CHAR_ONE: rd_data <= pause_char_one;
          `UFCE_A_PAUSE_CHAR_TWO: rd_data <= pause_char_two;
          `UFCE_A_ISR: rd_data <= interrupt_status_reg;
          default: rd_data <= `UFCE_RST_ZERO;
        endcase
    end
  end

  ufce_rx_match u_rx (
    .clock      (clock),
    .rst        (rst),
    .clk_en     (clk_en),
    .ffc        (ffc),
    .resume_char_one       (resume_char_one),
    .resume_char_two       (resume_char_two),
    .pause_char_one      (pause_char_one),
    .pause_char_two      (pause_char_two),
    .rx_valid   (rx_valid),
    .rx_char    (rx_char),
    .pause_hit  (pause_hit),
    .resume_hit (resume_hit),
    .spec_hit   (spec_hit),
    .drop_char  (),
    .wr_valid   (rx_wr_valid),
    .wr_char    (rx_wr_char)
  );

  assign rx_trigger_irq = ffc[`UFCE_F_ARTS] && (rx_fill >= TRIG_LEVEL);

  always @(posedge clock) begin
    if (rst) begin
      rts_armed <= 1'b0;
      auto_hi <= 1'b0;
      remote_paused <= 1'b0;
      we_paused <= 1'b0;
      send_pause <= 1'b0;
      send_resume <= 1'b0;
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
      infrared_tx_out <= 1'b0;
      irq_n <= 1'b1;
      tx_line_idle <= 1'b1;
    end else if (clk_en) begin
      dtr_n <= ~modem_control_reg[0];
      irq_n <= ~((interrupt_status_reg[5:4] & interrupt_enable_reg[5:4]) != 2'b00);
      tx_line_idle <= ~ser_valid;
      // arm once rts driven low by modem control
      if (!ffc[`UFCE_F_ARTS])
        rts_armed <= 1'b0;
      else if (modem_control_reg[`UFCE_MCR_RTS])
        rts_armed <= 1'b1;
      if (rx_fill >= UPPER_LEVEL)
        auto_hi <= 1'b1;
      else if (rx_fill < LOWER_LEVEL)
        auto_hi <= 1'b0;
      if (ffc[`UFCE_F_ARTS] && rts_armed)
        rts_n <= auto_hi | ~modem_control_reg[`UFCE_MCR_RTS];
      else
        rts_n <= ~modem_control_reg[`UFCE_MCR_RTS];
      if (ffc[1:0] == 2'b00)
        remote_paused <= 1'b0;
      else if (pause_hit)
        remote_paused <= 1'b1;
      else if (resume_hit)
        remote_paused <= 1'b0;
      // request pause/resume to remote from fill level
      send_pause <= 1'b0;
      send_resume <= 1'b0;
      if (ffc[3:2] != 2'b00) begin
        if (!we_paused && rx_fill >= UPPER_LEVEL) begin
          we_paused <= 1'b1;
          send_pause <= 1'b1;
        end else if (we_paused && rx_fill < LOWER_LEVEL) begin
          we_paused <= 1'b0;
          send_resume <= 1'b1;
        end
      end else
        we_paused <= 1'b0;
    end
  end

  ufce_tx_flow u_tx (
    .clock         (clock),
    .rst           (rst),
    .clk_en        (clk_en),
    .ffc           (ffc),
    .resume_char_one          (resume_char_one),
    .resume_char_two          (resume_char_two),
    .pause_char_one         (pause_char_one),
    .pause_char_two         (pause_char_two),
    .send_pause    (send_pause),
    .send_resume   (send_resume),
    .cts_sync_n    (cts_s[1]),
    .remote_paused (remote_paused),
    .data_valid    (tx_valid),
    .data_char     (tx_char),
    .data_ready    (tx_ready),
    .ser_ready     (ser_ready),
    .ser_valid     (ser_valid),
    .ser_char      (ser_char)
  );
endmodule

// *** test/ufce_chk.sv ***
module ufce_chk #(
  parameter UPPER_LEVEL = 8'd60,
  parameter LOWER_LEVEL = 8'd40,
  parameter TRIG_LEVEL  = 8'd56
) (
  // clock and reset
  input wire       clock,
  input wire       rst,
  // host bus
  input wire       wr_en,
  input wire       rd_en,
  input wire [7:0] rd_data,
  input wire       rd_data_oe,
  input wire       status_read_select_n,
  input wire [3:0] tx_space_ready_n,
  input wire [3:0] rx_data_ready_n,
  // modem pins
  input wire       rts_n,
  input wire       dtr_n,
  input wire       infrared_tx_out,
  input wire       irq_n,
  // data paths
  input wire       rx_valid,
  input wire [7:0] rx_char,
  input wire [7:0] rx_fill,
  input wire       rx_wr_valid,
  input wire [7:0] rx_wr_char,
  input wire       rx_trigger_irq,
  input wire       ser_valid,
  input wire       ser_ready,
  input wire [7:0] ser_char
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  a_reset_pins: assert property (disable iff (1'b0)
    rst |=> rts_n && dtr_n && !infrared_tx_out && irq_n && !ser_valid)
    else $error("pin levels wrong in reset");
  a_status_drive: assert property (
    !status_read_select_n [*3] |-> rd_data_oe)
    else $error("status byte not driven");
  a_bus_quiet: assert property (
    (status_read_select_n [*3]) ##0 !rd_en |-> !rd_data_oe)
    else $error("bus driven without request");
  a_status_view: assert property (
    (!status_read_select_n && $stable(tx_space_ready_n)
      && $stable(rx_data_ready_n)) [*5]
    |-> rd_data == {rx_data_ready_n, ~tx_space_ready_n})
    else $error("status byte wrong");
  a_store_source: assert property (
    rx_wr_valid |-> $past(rx_valid) && rx_wr_char == $past(rx_char))
    else $error("stored char without matching input");
  a_trigger_fill: assert property (
    rx_trigger_irq |-> rx_fill >= TRIG_LEVEL)
    else $error("trigger below level");
  a_rts_rise: assert property (
    $rose(rts_n) && !$past(wr_en) && !$past(wr_en, 2)
    |-> $past(rx_fill) >= UPPER_LEVEL)
    else $error("rts raised below upper level");
  a_rts_fall: assert property (
    $fell(rts_n) && !$past(wr_en) && !$past(wr_en, 2)
    |-> $past(rx_fill) < LOWER_LEVEL)
    else $error("rts lowered above lower level");
  a_ser_hold: assert property (
    ser_valid && !ser_ready |=> ser_valid && $stable(ser_char))
    else $error("serial char dropped before taken");
  c_stored: cover property (rx_wr_valid);
  c_rts_up: cover property (!rts_n ##1 rts_n);
  c_sent: cover property (ser_valid && ser_ready);
  c_pause_irq: cover property (!irq_n);
endmodule
bind ufce_top ufce_chk #(
  .UPPER_LEVEL(UPPER_LEVEL),
  .LOWER_LEVEL(LOWER_LEVEL),
  .TRIG_LEVEL(TRIG_LEVEL)
) u_ufce_chk (.clock, .rst, .wr_en, .rd_en, .rd_data, .rd_data_oe,
  .status_read_select_n, .tx_space_ready_n, .rx_data_ready_n, .rts_n,
  .dtr_n, .infrared_tx_out, .irq_n, .rx_valid, .rx_char, .rx_fill,
  .rx_wr_valid, .rx_wr_char, .rx_trigger_irq, .ser_valid, .ser_ready,
  .ser_char);

// *** test/ufce_remote.sv ***
module ufce_remote (
  // clock
  input  wire        clock,
  // characters sent by the block
  input  wire        ser_valid,
  input  wire  [7:0] ser_char,
  output logic       ser_ready,
  // characters sent to the block
  output logic       rx_valid,
  output logic [7:0] rx_char
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got [$];
  logic       slow = 1'b0;
  logic [1:0] tick = 2'h0;
  initial begin
    ser_ready = 1'b1;
    rx_valid = 1'b0;
    rx_char = 8'h00;
  end
  // slow mode takes one char in four cycles
  always @(negedge clock) begin
    tick <= tick + 2'h1;
    ser_ready <= !slow || tick == 2'h3;
  end
  always @(posedge clock)
    if (ser_valid && ser_ready)
      got.push_back(ser_char);
  task automatic send(input logic [7:0] c);
    @(negedge clock);
    rx_char = c;
    rx_valid = 1'b1;
    @(negedge clock);
    rx_valid = 1'b0;
    rx_char = ~c;
  endtask
endmodule

// *** test/tb_top.sv ***
`include "ufce_consts.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] UP = 8'd60;
  localparam logic [7:0] LO = 8'd40;
  localparam logic [7:0] TRIG = 8'd56;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic       clk_en = 1'b1;
  logic [3:0] addr = 4'h0;
  logic       wr_en = 1'b0;
  logic       rd_en = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic       status_read_select_n = 1'b1;
  logic [3:0] tx_space_ready_n = 4'h0;
  logic [3:0] rx_data_ready_n = 4'hf;
  logic       cts_n = 1'b0;
  logic [3:0] modem_in_n = 4'ha;
  logic [7:0] rx_fill = 8'h00;
  logic       tx_valid = 1'b0;
  logic [7:0] tx_char = 8'h00;
  logic       tx_taken = 1'b0;
  wire  [7:0] rd_data, rx_char, rx_wr_char, ser_char;
  wire        rd_data_oe, rts_n, dtr_n, infrared_tx_out, irq_n, rx_valid;
  wire        rx_wr_valid, rx_trigger_irq, tx_ready, ser_ready, ser_valid;
  wire        tx_line_idle;
  int         n_errors = 0;
  int         total_checks = 0;
  int         cycles = 0;
  int         n_wr = 0;
  logic [7:0] last_wr;
  logic [7:0] d;
  logic [7:0] flow_chars [4] = '{8'h11, 8'h21, 8'h13, 8'h23};
  logic [3:0] ra [10] = '{`UFCE_A_IER, `UFCE_A_FCR, `UFCE_A_LCR, `UFCE_A_MCR,
    `UFCE_A_LSR, `UFCE_A_MSR, `UFCE_A_SCR, `UFCE_A_FFC, `UFCE_A_PAUSE_CHAR_TWO,
    `UFCE_A_ISR};
  logic [7:0] rv [10] = '{`UFCE_RST_ZERO, `UFCE_RST_ZERO, 8'h00, 8'h00,
    `UFCE_RST_LSR, 8'h50, `UFCE_RST_SCR, 8'h00, 8'h00, `UFCE_RST_ISR};
  logic [7:0] tx_mode [3] = '{8'h18, 8'h14, 8'h1c};
  logic [7:0] tx_seq [3][4] = '{'{8'h13, 8'h11, 8'h00, 8'h00},
    '{8'h23, 8'h21, 8'h00, 8'h00}, '{8'h13, 8'h23, 8'h11, 8'h21}};
  int         tx_len [3] = '{2, 2, 4};
  logic [7:0] rx_mode [4] = '{8'h12, 8'h13, 8'h1b, 8'h90};
  logic [7:0] rx_off [4][2] = '{'{8'h13, 8'h00}, '{8'h13, 8'h23},
    '{8'h23, 8'h00}, '{8'h00, 8'h00}};
  logic [7:0] rx_on [4][2] = '{'{8'h11, 8'h00}, '{8'h11, 8'h21},
    '{8'h21, 8'h00}, '{8'h00, 8'h00}};
  int         rx_len [4] = '{1, 2, 1, 0};
  logic [7:0] rts_fill [4] = '{UP - 8'h01, UP, LO, LO - 8'h01};
  logic       rts_want [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

  ufce_top #(.UPPER_LEVEL(UP), .LOWER_LEVEL(LO), .TRIG_LEVEL(TRIG)) u_ufce_top (
    .clock, .rst, .clk_en, .addr, .wr_en, .rd_en, .wr_data, .rd_data,
    .rd_data_oe, .status_read_select_n, .tx_space_ready_n, .rx_data_ready_n,
    .cts_n, .modem_in_n, .rts_n, .dtr_n, .infrared_tx_out, .irq_n, .rx_valid,
    .rx_char, .rx_fill, .rx_wr_valid, .rx_wr_char, .rx_trigger_irq,
    .tx_valid, .tx_char, .tx_ready, .ser_ready, .ser_valid, .ser_char,
    .tx_line_idle);
  ufce_remote u_ufce_remote (.clock, .ser_valid, .ser_char, .ser_ready,
    .rx_valid, .rx_char);

  always #4 clock = ~clock;
  always @(posedge clock)
    tx_taken <= tx_valid && tx_ready;
  always @(negedge clock)
    if (tx_taken)
      tx_valid = 1'b0;
  always @(posedge clock)
    if (rx_wr_valid === 1'b1) begin
      n_wr++;
      last_wr = rx_wr_char;
    end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic do_reset;
    @(negedge clock);
    rst = 1'b1;
    repeat (6) @(negedge clock);
    rst = 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(negedge clock);
    addr = a;
    wr_data = v;
    wr_en = 1'b1;
    @(negedge clock);
    wr_en = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(negedge clock);
    addr = a;
    rd_en = 1'b1;
    @(negedge clock);
    v = rd_data;
    rd_en = 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [3:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk(nm, v, e);
  endtask
  task automatic rx_try(input logic [7:0] c, input logic s);
    int n0;
    n0 = n_wr;
    u_ufce_remote.send(c);
    @(negedge clock);
    chk("stored count", 8'(n_wr - n0), {7'h0, s});
  endtask
  task automatic offer(input logic [7:0] c);
    @(negedge clock);
    tx_char = c;
    tx_valid = 1'b1;
  endtask
  task automatic wait_got(input int n);
    for (int i = 0; i < 300 && u_ufce_remote.got.size() < n; i++)
      @(negedge clock);
  endtask

  initial begin
    do_reset();
    for (int i = 0; i < 10; i++)
      rdc("reset value", ra[i], rv[i]);
    chk("reset pins", {4'h0, rts_n, dtr_n, infrared_tx_out, irq_n}, 8'h0d);
    chk("idle line", {7'h0, tx_line_idle}, 8'h01);
    status_read_select_n = 1'b0;
    repeat (4) @(negedge clock);
    chk("status reset", rd_data, `UFCE_RST_QUAD_FIFO_STATUS);
    tx_space_ready_n = 4'h2;
    rx_data_ready_n = 4'h9;
    repeat (4) @(negedge clock);
    chk("status view", rd_data, 8'h9d);
    chk("status drive", {7'h0, rd_data_oe}, 8'h01);
    status_read_select_n = 1'b1;
    repeat (4) @(negedge clock);
    for (int i = 0; i < 4; i++) begin
      wr(`UFCE_A_RESUME_CHAR_ONE + 4'(i), flow_chars[i]);
      rdc("flow char", `UFCE_A_RESUME_CHAR_ONE + 4'(i), flow_chars[i]);
    end
    wr(`UFCE_A_IER, 8'hff);
    rdc("locked enable", `UFCE_A_IER, 8'h0f);
    wr(`UFCE_A_FFC, 8'h10);
    wr(`UFCE_A_IER, 8'hff);
    rdc("open enable", `UFCE_A_IER, 8'hff);
    wr(`UFCE_A_FFC, 8'h00);
    wr(`UFCE_A_IER, 8'h00);
    rdc("held enable", `UFCE_A_IER, 8'hf0);
    wr(`UFCE_A_FFC, 8'h32);
    rx_try(8'h23, 1'b1);
    chk("special char", last_wr, 8'h23);
    rd(`UFCE_A_ISR, d);
    chk("special flag", d & 8'h10, 8'h10);
    rx_try(8'h13, 1'b0);
    rx_try(8'h21, 1'b1);
    wr(`UFCE_A_FFC, 8'h10);
    wr(`UFCE_A_IER, 8'h20);
    wr(`UFCE_A_ISR, 8'h00);
    rd(`UFCE_A_ISR, d);
    chk("cleared flags", d & 8'h30, 8'h00);
    chk("quiet irq", {7'h0, irq_n}, 8'h01);
    wr(`UFCE_A_FFC, 8'h31);
    rx_try(8'h23, 1'b0);
    rd(`UFCE_A_ISR, d);
    chk("pause flag", d & 8'h20, 8'h20);
    chk("special again", d & 8'h10, 8'h10);
    chk("irq pin", {7'h0, irq_n}, 8'h00);
    rx_try(8'h13, 1'b1);
    u_ufce_remote.slow = 1'b1;
    for (int m = 0; m < 4; m++) begin
      wr(`UFCE_A_FFC, 8'h10);
      cts_n = (m == 3);
      wr(`UFCE_A_FFC, rx_mode[m]);
      u_ufce_remote.got.delete();
      for (int k = 0; k < rx_len[m]; k++)
        u_ufce_remote.send(rx_off[m][k]);
      offer(8'h41 + 8'(m));
      repeat (20) @(negedge clock);
      chk("held data", 8'(u_ufce_remote.got.size()), 8'h00);
      cts_n = 1'b0;
      for (int k = 0; k < rx_len[m]; k++)
        u_ufce_remote.send(rx_on[m][k]);
      wait_got(1);
      chk("released data", u_ufce_remote.got[0], 8'h41 + 8'(m));
    end
    u_ufce_remote.slow = 1'b0;
    for (int m = 0; m < 3; m++) begin
      wr(`UFCE_A_FFC, 8'h10);
      wr(`UFCE_A_FFC, tx_mode[m]);
      u_ufce_remote.got.delete();
      rx_fill = UP;
      wait_got(tx_len[m] / 2);
      rx_fill = LO - 8'h01;
      wait_got(tx_len[m]);
      repeat (8) @(negedge clock);
      chk("flow count", 8'(u_ufce_remote.got.size()), 8'(tx_len[m]));
      for (int k = 0; k < tx_len[m]; k++)
        chk("flow char sent", u_ufce_remote.got[k], tx_seq[m][k]);
    end
    do_reset();
    rdc("cleared enable", `UFCE_A_IER, 8'h00);
    wr(`UFCE_A_FFC, 8'h50);
    rx_fill = UP;
    repeat (3) @(negedge clock);
    rx_fill = LO - 8'h01;
    repeat (3) @(negedge clock);
    chk("unarmed rts", {7'h0, rts_n}, 8'h01);
    wr(`UFCE_A_MCR, 8'h02);
    repeat (2) @(negedge clock);
    chk("armed rts", {7'h0, rts_n}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rx_fill = rts_fill[i];
      repeat (3) @(negedge clock);
      chk("auto rts", {7'h0, rts_n}, {7'h0, rts_want[i]});
      chk("trigger", {7'h0, rx_trigger_irq}, {7'h0, rts_fill[i] >= TRIG});
    end
    wr(`UFCE_A_FFC, 8'h10);
    wr(`UFCE_A_MCR, 8'h00);
    repeat (2) @(negedge clock);
    chk("plain rts", {7'h0, rts_n}, 8'h01);
    complete_run();
  end
endmodule
